// ### rtl/monitor_cfg_defs.svh
// Purpose: offsets, field positions, reset values of the monitor configuration
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef MONITOR_CFG_DEFS_SVH
`define MONITOR_CFG_DEFS_SVH

// ==========================================================================
// register offsets
`define OFS_PRIMARY_CFG    8'h00
`define OFS_SECONDARY_CFG  8'h01
`define OFS_TERTIARY_CFG   8'h07
`define OFS_GPIO_CFG_FIRST 8'h08
`define OFS_GPIO_CFG_LAST  8'h0B
`define OFS_LIMIT_FIRST    8'h0D
`define OFS_LIMIT_LAST     8'h12
`define OFS_MASK_FIRST     8'h18
`define OFS_STATUS4        8'h23
`define OFS_STATUS6        8'h25
`define OFS_VALUE_FIRST    8'h1F
`define OFS_VALUE_LAST     8'h3F
`define OFS_LIMIT2_FIRST   8'h40
`define OFS_LIMIT2_LAST    8'h6D
`define OFS_EXT_OFS_FIRST  8'h6E
`define OFS_EXT_OFS_LAST   8'h6F

// ==========================================================================
// primary configuration fields
`define PCFG_RUN        0
`define PCFG_INT_EN     1
`define PCFG_INT_CLR    2
`define PCFG_AUX_SEL    3
`define PCFG_OT_EN      4
`define PCFG_AFC_DAC    5
`define PCFG_AFC_PWM    6
`define PCFG_SOFT_RST   7

// ==========================================================================
// tertiary configuration fields
`define TCFG_PIN_GPIO   0
`define TCFG_CI_CLR     1
`define TCFG_VREF_HI    2
`define TCFG_DIR        6
`define TCFG_POL        7
`define TCFG_USED_MASK  8'hC7

// ==========================================================================
// reset values
`define RST_ZERO        8'h00
`define RST_FAN_DIV     8'h55
`define RST_FAN_DRV     8'hFF
`define RST_OVERTEMP_SIGNAL_INT   8'h37
`define RST_OVERTEMP_SIGNAL_EXT   8'h50
`define RST_TMIN_INT    8'h28
`define RST_TMIN_EXT    8'h40

`endif

// ### rtl/monitor_cfg_pkg.sv
// Purpose: types shared by the monitor configuration design
// Assumes: nothing
// Notes:   constants live in monitor_cfg_defs.svh
package monitor_cfg_pkg;
    // ======================================================================
    // loop control states, gray coded except the RUN to IDLE step
    typedef enum logic [1:0] {
        LOOP_IDLE  = 2'b00,
        LOOP_START = 2'b01,
        LOOP_RUN   = 2'b11
    } loop_state_t;
endpackage

// ### rtl/monitor_config_control.sv
// Purpose: register file and control outputs of a hardware monitor
// Assumes: single 125 MHz clock, synchronous active high reset
// Notes:   256-byte map; unimplemented offsets read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "monitor_cfg_defs.svh"

module monitor_config_control
    import monitor_cfg_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // events from the monitor core
    input  wire logic       alert_event,
    input  wire logic       intrusion_pin,
    input  wire logic [7:0] value_in,
    input  wire logic [7:0] value_addr,
    input  wire logic       value_we,
    // control outputs
    output logic            alert_n,
    output logic            adc_enable,
    output logic            meas_start,
    output logic            fan_meas_run,
    output logic            aux_input_sel,
    output logic            overtemp_enable,
    output logic            afc_dac_enable,
    output logic            afc_pwm_enable,
    output logic            overtemp_pin_is_gpio,
    output logic            chassis_intrusion,
    output logic            vref_high,
    output logic            spare_io_seventeenth_oe,
    output logic            spare_io_seventeenth_pol
);

    // ======================================================================
    // storage
    logic [7:0]  regs_ff [0:255];
    logic        soft_rst_ff;
    logic        alert_ff;
    logic        ci_latch_ff;
    logic        ci_meta_ff;
    logic        ci_sync_ff;
    loop_state_t loop_ff;
    loop_state_t nxt_loop;
    logic        wr_pcfg;
    logic        wr_tcfg;
    integer      i;

    // limit offsets; a software reset leaves these and offset 0 alone
    function automatic logic is_limit(input logic [7:0] a);
        is_limit = (a >= `OFS_LIMIT_FIRST && a <= `OFS_LIMIT_LAST) ||
                   (a >= `OFS_LIMIT2_FIRST && a <= `OFS_LIMIT2_LAST);
    endfunction

    // offsets that exist in the map
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a <= `OFS_EXT_OFS_LAST);
    endfunction

    // power-on default of each offset
    function automatic logic [7:0] default_of(input logic [7:0] a);
        case (a)
            8'h02, 8'h03: default_of = `RST_FAN_DIV;
            8'h04, 8'h05: default_of = `RST_FAN_DRV;
            8'h0D:        default_of = `RST_OVERTEMP_SIGNAL_INT;
            8'h0E, 8'h0F: default_of = `RST_OVERTEMP_SIGNAL_EXT;
            8'h10:        default_of = `RST_TMIN_INT;
            8'h11, 8'h12: default_of = `RST_TMIN_EXT;
            default:      default_of = `RST_ZERO;
        endcase
    endfunction

    assign wr_pcfg = reg_wr && (reg_addr == `OFS_PRIMARY_CFG);
    assign wr_tcfg = reg_wr && (reg_addr == `OFS_TERTIARY_CFG);

    // ======================================================================
    // register array: power-on, soft reset, host and core writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (i = 0; i < 256; i = i + 1) begin
                regs_ff[i] <= default_of(8'(i));
            end
        end else begin
            if (soft_rst_ff) begin
                for (i = 0; i < 256; i = i + 1) begin
                    if (!is_limit(8'(i)) && i != 0) begin
                        regs_ff[i] <= default_of(8'(i));
                    end
                end
            end
            if (value_we && is_mapped(value_addr) && !is_limit(value_addr)) begin
                regs_ff[value_addr] <= value_in;
            end
            // host writes are honoured in every mode
            if (reg_wr && is_mapped(reg_addr)) begin
                if (reg_addr == `OFS_TERTIARY_CFG) begin
                    regs_ff[reg_addr] <= reg_wdata & `TCFG_USED_MASK;
                end else begin
                    regs_ff[reg_addr] <= reg_wdata;
                end
            end else if (soft_rst_ff) begin
                regs_ff[0] <= regs_ff[0];
            end
        end
    end

    // ======================================================================
    // soft reset pulse, once after the setting write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= wr_pcfg && reg_wdata[`PCFG_SOFT_RST];
        end
    end

    // ======================================================================
    // read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && is_mapped(reg_addr)) begin
            reg_rdata <= regs_ff[reg_addr];
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ======================================================================
    // monitoring loop control
    always_comb begin
        nxt_loop = loop_ff;
        case (loop_ff)
            LOOP_IDLE:  if (regs_ff[0][`PCFG_RUN]) nxt_loop = LOOP_START;
            LOOP_START: nxt_loop = regs_ff[0][`PCFG_RUN] ? LOOP_RUN : LOOP_IDLE;
            LOOP_RUN:   if (!regs_ff[0][`PCFG_RUN]) nxt_loop = LOOP_IDLE;
            default:    nxt_loop = LOOP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loop_ff <= LOOP_IDLE;
        end else begin
            loop_ff <= nxt_loop;
        end
    end

    // common start, then analog and fan paths free-run
    assign meas_start   = (loop_ff == LOOP_START);
    assign adc_enable   = (loop_ff != LOOP_IDLE);
    assign fan_meas_run = (loop_ff != LOOP_IDLE);

    // ======================================================================
    // alert latch, cleared by the clear bit; set wins only when not clearing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alert_ff <= 1'b0;
        end else if (regs_ff[0][`PCFG_INT_CLR]) begin
            alert_ff <= 1'b0;
        end else if (alert_event) begin
            alert_ff <= 1'b1;
        end
    end

    assign alert_n = !(alert_ff && regs_ff[0][`PCFG_INT_EN]
                       && !regs_ff[0][`PCFG_INT_CLR]);

    // ======================================================================
    // chassis intrusion input sync and latch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ci_meta_ff <= 1'b0;
            ci_sync_ff <= 1'b0;
        end else begin
            ci_meta_ff <= intrusion_pin;
            ci_sync_ff <= ci_meta_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ci_latch_ff <= 1'b0;
        end else if (regs_ff[`OFS_TERTIARY_CFG][`TCFG_CI_CLR]) begin
            ci_latch_ff <= 1'b0;
        end else if (ci_sync_ff) begin
            ci_latch_ff <= 1'b1;
        end
    end

    // ======================================================================
    // decoded configuration outputs
    assign aux_input_sel   = regs_ff[0][`PCFG_AUX_SEL];
    assign overtemp_enable = regs_ff[0][`PCFG_OT_EN];
    assign afc_dac_enable  = regs_ff[0][`PCFG_AFC_DAC];
    assign afc_pwm_enable  = regs_ff[0][`PCFG_AFC_PWM];
    assign overtemp_pin_is_gpio =
        regs_ff[`OFS_TERTIARY_CFG][`TCFG_PIN_GPIO];
    assign vref_high =
        regs_ff[`OFS_TERTIARY_CFG][`TCFG_VREF_HI];
    assign spare_io_seventeenth_oe =
        regs_ff[`OFS_TERTIARY_CFG][`TCFG_DIR];
    assign spare_io_seventeenth_pol =
        regs_ff[`OFS_TERTIARY_CFG][`TCFG_POL];
    assign chassis_intrusion = ci_latch_ff;

    // ======================================================================
    // checks
    chk_soft_once: assert property (@(posedge clk) disable iff (sys_rst)
        soft_rst_ff |=> !soft_rst_ff || $past(wr_pcfg))
        else $error("soft reset pulse repeated");
    chk_soft_cause: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_pcfg && reg_wdata[7]) |=> soft_rst_ff)
        else $error("soft reset not applied");
    chk_limit_keep: assert property (@(posedge clk) disable iff (sys_rst)
        (soft_rst_ff && !(reg_wr && reg_addr == 8'h0D) && !value_we)
        |=> regs_ff[8'h0D] == $past(regs_ff[8'h0D]))
        else $error("limit changed by soft reset");
    chk_cfg2_reset: assert property (@(posedge clk) disable iff (sys_rst)
        (soft_rst_ff && !reg_wr && !value_we) |=> regs_ff[1] == 8'h00)
        else $error("config two not reset");
    chk_adc_off: assert property (@(posedge clk) disable iff (sys_rst)
        !regs_ff[0][0] |=> !adc_enable)
        else $error("converter on while stopped");
    chk_run_start: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(regs_ff[0][0]) ##1 regs_ff[0][0]) |-> meas_start ##1 adc_enable)
        else $error("loop did not start");
    chk_alert_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !regs_ff[0][1] |-> alert_n)
        else $error("alert driven while disabled");
    chk_alert_clr: assert property (@(posedge clk) disable iff (sys_rst)
        regs_ff[0][2] |=> !alert_ff)
        else $error("alert not cleared");
    chk_ci_clear: assert property (@(posedge clk) disable iff (sys_rst)
        regs_ff[7][1] |=> !ci_latch_ff)
        else $error("intrusion latch not cleared");
    chk_read_data: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == 8'h00 && !reg_wr) |=>
        reg_rdata == $past(regs_ff[0]))
        else $error("read data wrong");
    chk_rd_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");

    // ======================================================================
    // power-on defaults, checked on the edge after reset
    chk_por_defaults: assert property (@(posedge clk)
        sys_rst |=> (!spare_io_seventeenth_oe && alert_n && !adc_enable))
        else $error("outputs not at power-on state");
    chk_por_limit: assert property (@(posedge clk)
        sys_rst |=> regs_ff[8'h0D] == `RST_OVERTEMP_SIGNAL_INT)
        else $error("limit not restored by power-on");

    // ======================================================================
    // software reset reach
    chk_soft_value: assert property (@(posedge clk) disable iff (sys_rst)
        (soft_rst_ff && !reg_wr && !value_we) |=> (regs_ff[8'h1F] == 8'h00
        && regs_ff[8'h6E] == 8'h00 && regs_ff[8'h18] == 8'h00))
        else $error("value, mask or offset not reset");
    chk_soft_pcfg: assert property (@(posedge clk) disable iff (sys_rst)
        (soft_rst_ff && !reg_wr && !value_we)
        |=> regs_ff[0] == $past(regs_ff[0]))
        else $error("soft reset bit did not keep value");

    // ======================================================================
    // primary configuration outputs follow the host write; loop outputs follow the run bit
    chk_aux_follow: assert property (@(posedge clk) disable iff (sys_rst)
        wr_pcfg |=> aux_input_sel == $past(reg_wdata[`PCFG_AUX_SEL]))
        else $error("aux select wrong");
    chk_ot_follow: assert property (@(posedge clk) disable iff (sys_rst)
        wr_pcfg |=> overtemp_enable == $past(reg_wdata[`PCFG_OT_EN]))
        else $error("overtemp enable wrong");
    chk_afc_dac: assert property (@(posedge clk) disable iff (sys_rst)
        wr_pcfg |=> afc_dac_enable == $past(reg_wdata[`PCFG_AFC_DAC]))
        else $error("dac fan control enable wrong");
    chk_afc_pwm: assert property (@(posedge clk) disable iff (sys_rst)
        wr_pcfg |=> afc_pwm_enable == $past(reg_wdata[`PCFG_AFC_PWM]))
        else $error("pwm fan control enable wrong");
    chk_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !regs_ff[0][`PCFG_RUN] |=> (!fan_meas_run && !meas_start))
        else $error("loop running while stopped");
    chk_start_once: assert property (@(posedge clk) disable iff (sys_rst)
        meas_start |=> !meas_start)
        else $error("start pulse longer than one cycle");
    chk_start_both: assert property (@(posedge clk) disable iff (sys_rst)
        meas_start |-> (adc_enable && fan_meas_run))
        else $error("paths did not start together");

    // ======================================================================
    // tertiary configuration outputs follow the host write
    chk_gpio_role: assert property (@(posedge clk) disable iff (sys_rst)
        wr_tcfg |=> overtemp_pin_is_gpio == $past(reg_wdata[`TCFG_PIN_GPIO]))
        else $error("shared pin role wrong");
    chk_vref_sel: assert property (@(posedge clk) disable iff (sys_rst)
        wr_tcfg |=> vref_high == $past(reg_wdata[`TCFG_VREF_HI]))
        else $error("reference select wrong");
    chk_dir_follow: assert property (@(posedge clk) disable iff (sys_rst)
        wr_tcfg |=> spare_io_seventeenth_oe == $past(reg_wdata[`TCFG_DIR]))
        else $error("spare pin direction wrong");
    chk_pol_follow: assert property (@(posedge clk) disable iff (sys_rst)
        wr_tcfg |=> spare_io_seventeenth_pol == $past(reg_wdata[`TCFG_POL]))
        else $error("spare pin polarity wrong");
    chk_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
        wr_tcfg |=> regs_ff[`OFS_TERTIARY_CFG][5:3] == 3'b000)
        else $error("unused tertiary bits stored");

    // ======================================================================
    // latches: setting paths and what the alert clear leaves alone
    chk_alert_sets: assert property (@(posedge clk) disable iff (sys_rst)
        (alert_event && !regs_ff[0][`PCFG_INT_CLR]) |=> alert_ff)
        else $error("alert event lost");
    chk_clr_keeps_ci: assert property (@(posedge clk) disable iff (sys_rst)
        (regs_ff[0][`PCFG_INT_CLR] && ci_latch_ff
        && !regs_ff[`OFS_TERTIARY_CFG][`TCFG_CI_CLR]) |=> ci_latch_ff)
        else $error("alert clear touched intrusion latch");
    chk_ci_sets: assert property (@(posedge clk) disable iff (sys_rst)
        (ci_sync_ff && !regs_ff[`OFS_TERTIARY_CFG][`TCFG_CI_CLR])
        |=> ci_latch_ff)
        else $error("intrusion event lost");

endmodule
`default_nettype wire

// ### sim/mon_host_model.sv
// Purpose: bus host driving the plain register port of the monitor
// Assumes: one clock; requests change by nonblocking assignment after posedge
// Notes:   one request at a time, so the strobes never overlap
`timescale 1ns/1ps
`default_nettype none
module mon_host_model (
    // clock
    input  wire logic       clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // ==========================================================
    // idle state of the port
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'hA5;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // ==========================================================
    // write: one cycle strobe, stale data inverted afterwards
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // read: data taken in the cycle after the strobe only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### sim/monitor_config_control_test.sv
// Purpose: self-checking bench of the monitor configuration block
// Assumes: 125 MHz clock, synchronous active high reset
// Notes:   host model drives the register port, bench drives core events
`timescale 1ns/1ps
`default_nettype none
module monitor_config_control_test;
    import monitor_cfg_pkg::*;
    logic       clk, sys_rst, reg_wr, reg_rd, value_we;
    logic       alert_event, intrusion_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, value_in, value_addr;
    logic       alert_n, adc_enable, meas_start, fan_meas_run, aux_input_sel;
    logic       overtemp_enable, afc_dac_enable, afc_pwm_enable;
    logic       overtemp_pin_is_gpio, chassis_intrusion, vref_high;
    logic       spare_io_seventeenth_oe, spare_io_seventeenth_pol;
    int         errors, comparisons;
    logic [7:0] ra [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h07, 8'h08, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h18, 8'h6E};
    logic [7:0] re [16] = '{8'h00, 8'h00, 8'h55, 8'h55, 8'hFF, 8'hFF,
        8'h00, 8'h00, 8'h37, 8'h50, 8'h50, 8'h28, 8'h40, 8'h40, 8'h00, 8'h00};

    // ==========================================================
    // clock and instances
    always #4 clk = ~clk;

    mon_host_model host (.clk(clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    monitor_config_control dut (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert_event(alert_event),
        .intrusion_pin(intrusion_pin), .value_in(value_in),
        .value_addr(value_addr), .value_we(value_we), .alert_n(alert_n),
        .adc_enable(adc_enable), .meas_start(meas_start),
        .fan_meas_run(fan_meas_run), .aux_input_sel(aux_input_sel),
        .overtemp_enable(overtemp_enable), .afc_dac_enable(afc_dac_enable),
        .afc_pwm_enable(afc_pwm_enable),
        .overtemp_pin_is_gpio(overtemp_pin_is_gpio),
        .chassis_intrusion(chassis_intrusion), .vref_high(vref_high),
        .spare_io_seventeenth_oe(spare_io_seventeenth_oe),
        .spare_io_seventeenth_pol(spare_io_seventeenth_pol));

    // ==========================================================
    // compare, read-compare, settle and closing tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic end_sim();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // synchroniser delay on the intrusion pin, bounded wait
    task automatic wait_ci();
        int n;
        n = 0;
        while (chassis_intrusion !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk(8'(chassis_intrusion), 8'h01);
        if (chassis_intrusion !== 1'b1) begin
            end_sim();
        end
    endtask

    // one-cycle core event pulses
    task automatic pulse_alert();
        @(posedge clk);
        alert_event <= 1'b1;
        @(posedge clk);
        alert_event <= 1'b0;
        tick(1);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clk = 1'b0; sys_rst = 1'b1; alert_event = 1'b0;
        intrusion_pin = 1'b0; value_in = 8'h00;
        value_addr = 8'h00; value_we = 1'b0;
        errors = 0; comparisons = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        tick(0);
        chk(8'(alert_n), 8'h01);
        chk(8'(spare_io_seventeenth_oe), 8'h00);
        for (int i = 0; i < 16; i++) rdchk(ra[i], re[i]);
        // core writes a value register and, wrongly, a limit offset
        @(posedge clk);
        value_addr <= 8'h1F; value_in <= 8'h77; value_we <= 1'b1;
        @(posedge clk);
        value_addr <= 8'h0E; value_in <= 8'h99;
        @(posedge clk);
        value_we <= 1'b0;
        rdchk(8'h1F, 8'h77);
        rdchk(8'h0E, 8'h50);
        // soft reset restores a subset, limits kept
        host.wr(8'h02, 8'h12); host.wr(8'h18, 8'h34);
        host.wr(8'h6E, 8'h56); host.wr(8'h0D, 8'hAA);
        host.wr(8'h40, 8'hBB); host.wr(8'h07, 8'h04);
        host.wr(8'h00, 8'h80);
        tick(1);
        rdchk(8'h00, 8'h80);
        rdchk(8'h02, 8'h55); rdchk(8'h18, 8'h00);
        rdchk(8'h6E, 8'h00); rdchk(8'h1F, 8'h00);
        rdchk(8'h07, 8'h00);
        rdchk(8'h0D, 8'hAA); rdchk(8'h40, 8'hBB);
        host.wr(8'h02, 8'h12);
        rdchk(8'h02, 8'h12);
        host.wr(8'h00, 8'h00);
        rdchk(8'h00, 8'h00);
        // loop start pulse, then low power with bus still usable
        host.wr(8'h00, 8'h01);
        tick(0);
        chk(8'(meas_start), 8'h00);
        tick(1);
        chk({5'h00, meas_start, adc_enable, fan_meas_run}, 8'h07);
        tick(1);
        chk(8'(meas_start), 8'h00);
        host.wr(8'h00, 8'h00);
        tick(2);
        chk({6'h00, adc_enable, fan_meas_run}, 8'h00);
        host.wr(8'h05, 8'h3C);
        rdchk(8'h05, 8'h3C);
        // one enable bit at a time
        for (int k = 3; k < 7; k++) begin
            host.wr(8'h00, 8'h01 << k);
            tick(0);
            chk({4'h0, afc_pwm_enable, afc_dac_enable, overtemp_enable,
                aux_input_sel}, 8'h01 << (k - 3));
        end
        // tertiary fields and unused bits
        host.wr(8'h07, 8'hFF);
        rdchk(8'h07, 8'hC7);
        host.wr(8'h07, 8'h85);
        tick(0);
        chk({4'h0, spare_io_seventeenth_pol, spare_io_seventeenth_oe,
            vref_high, overtemp_pin_is_gpio}, 8'h0B);
        // intrusion latch set, held clear, rearmed
        host.wr(8'h07, 8'h00);
        intrusion_pin <= 1'b1;
        wait_ci();
        host.wr(8'h07, 8'h02);
        tick(3);
        chk(8'(chassis_intrusion), 8'h00);
        intrusion_pin <= 1'b0;
        host.wr(8'h07, 8'h00);
        tick(3);
        chk(8'(chassis_intrusion), 8'h00);
        intrusion_pin <= 1'b1;
        wait_ci();
        // alert gating and clearing
        host.wr(8'h00, 8'h11);
        pulse_alert();
        chk(8'(alert_n), 8'h01);
        host.wr(8'h00, 8'h13);
        tick(0);
        chk(8'(alert_n), 8'h00);
        host.wr(8'h00, 8'h17);
        tick(0);
        chk(8'(alert_n), 8'h01);
        chk(8'(chassis_intrusion), 8'h01);
        // unmapped offset
        host.wr(8'hFF, 8'h5A);
        rdchk(8'hFF, 8'h00);
        // mid-run reset restores limits and stops the loop
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        tick(0);
        chk({6'h00, adc_enable, spare_io_seventeenth_oe}, 8'h00);
        rdchk(8'h0D, 8'h37); rdchk(8'h40, 8'h00);
        rdchk(8'h00, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
